//--- shared/raster_timing_regs.svh
// register indices, field positions and reset values of the raster timing generator
// assumes inclusion by bare name from design files only
`ifndef RASTER_TIMING_REGS_SVH
`define RASTER_TIMING_REGS_SVH

// register indices reached through the index register
`define IDX_HTOTAL 5'h00
`define IDX_HDISP 5'h01
`define IDX_HSYNC_POS 5'h02
`define IDX_SYNC_WIDTHS 5'h03
`define IDX_VTOTAL 5'h04
`define IDX_VADJUST 5'h05
`define IDX_VDISP 5'h06
`define IDX_VSYNC_POS 5'h07
`define IDX_MODE 5'h08
`define IDX_ROW_LINES 5'h09
`define IDX_CUR_START 5'h0A
`define IDX_CUR_END 5'h0B
`define IDX_START_HI 5'h0C
`define IDX_START_LO 5'h0D
`define IDX_CUR_HI 5'h0E
`define IDX_CUR_LO 5'h0F
`define IDX_PEN_HI 5'h10
`define IDX_PEN_LO 5'h11

// field positions
`define MODE_ROWCOL_BIT 2
`define MODE_SHARED_BIT 3
`define MODE_CUR_DELAY_BIT 5
`define HSYNC_W_LSB 0
`define VSYNC_W_LSB 4
`define BLINK_LSB 5
`define BLINK_FAST_BIT 3
`define BLINK_SLOW_BIT 4

// reset values
`define RST_BYTE 8'h00
`define RST_ADDR 14'h0000

`endif

//--- shared/raster_timing_pkg.sv
// types shared by the raster timing generator and its bench
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package raster_timing_pkg;

   // one processor bus cycle, sampled on ref_clk
   typedef struct packed {
      logic cs_n;
      logic register_select;
      logic read_not_write;
      logic strobe;
      logic [7:0] data;
   } bus_req_t;

   // video side outputs
   typedef struct packed {
      logic hsync;
      logic vsync;
      logic display_enable;
      logic cursor;
      logic [13:0] refresh_address_out;
      logic [4:0] scan_row_address_out;
   } video_out_t;

   // cursor blink modes
   typedef enum logic [1:0] {
      BLINK_STEADY = 2'h0,
      BLINK_OFF = 2'h1,
      BLINK_FAST = 2'h2,
      BLINK_SLOW = 2'h3
   } blink_mode_t;

   // frame phase, one-hot
   typedef enum logic [1:0] {
      PH_ROWS = 2'h1,
      PH_ADJUST = 2'h2
   } frame_phase_t;

endpackage

`default_nettype wire

//--- logic/raster_video_timing_generator.sv
// raster timing generator: counters, syncs, refresh address, cursor, pen capture
// assumes ref_clk gated by clk_en is the character clock; bus inputs synchronous
`timescale 1ns/100ps
`default_nettype none
`include "raster_timing_regs.svh"

module raster_video_timing_generator
   import raster_timing_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   output logic bus_rdata_oe,
   input wire logic pen_strobe_input,
   output video_out_t video
);

   // read decode, used by the registered read path only
   function automatic logic [7:0] read_mux(input logic [4:0] idx, input logic [13:0] cur,
                                           input logic [13:0] pen);
      case (idx)
         `IDX_CUR_HI: read_mux = {2'h0, cur[13:8]};
         `IDX_CUR_LO: read_mux = cur[7:0];
         `IDX_PEN_HI: read_mux = {2'h0, pen[13:8]};
         `IDX_PEN_LO: read_mux = pen[7:0];
         default: read_mux = 8'h00;
      endcase
   endfunction

   logic [4:0] index_q;
   logic [7:0] htotal_q, hdisp_q, hsync_position_q, sync_widths_q, mode_control_q;
   logic [6:0] vertical_total_rows_q, vertical_displayed_rows_q, vsync_row_position_q;
   logic [4:0] vertical_line_adjust_q, row_scan_lines_q, cursor_end_line_q;
   logic [6:0] cursor_start_line_q;
   logic [13:0] display_start_q, cursor_address_q, pen_capture_q;
   logic [7:0] rdata_q;
   logic rdata_oe_q;

   logic [7:0] hcnt_q;
   logic [4:0] scan_q;
   logic [6:0] row_q;
   logic [13:0] row_base_q;
   logic [4:0] field_q;
   frame_phase_t phase_q;
   logic hsync_q, vsync_q;
   logic [3:0] hs_cnt_q, vs_cnt_q;
   logic cur_now_q, pen_prev_q;
   video_out_t video_q;

   logic wr_acc, rd_acc, line_end, row_end, frame_end, rowcol;
   logic [13:0] ma;
   logic [3:0] hs_width, vs_width;
   logic blink_on, cur_hit;
   logic [7:0] hnext;
   logic vs_start;

   assign wr_acc = clk_en && !bus_req.cs_n && bus_req.strobe && !bus_req.read_not_write;
   assign rd_acc = clk_en && !bus_req.cs_n && bus_req.strobe && bus_req.read_not_write;
   assign hs_width = sync_widths_q[`HSYNC_W_LSB +: 4];
   assign vs_width = sync_widths_q[`VSYNC_W_LSB +: 4];
   assign rowcol = mode_control_q[`MODE_ROWCOL_BIT];

   // index register and timing registers, write-only except the cursor pair
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         index_q <= 5'h00;
         htotal_q <= `RST_BYTE;
         hdisp_q <= `RST_BYTE;
         hsync_position_q <= `RST_BYTE;
         sync_widths_q <= `RST_BYTE;
         mode_control_q <= `RST_BYTE;
         vertical_total_rows_q <= 7'h00;
         vertical_line_adjust_q <= 5'h00;
         vertical_displayed_rows_q <= 7'h00;
         vsync_row_position_q <= 7'h00;
         row_scan_lines_q <= 5'h00;
         cursor_start_line_q <= 7'h00;
         cursor_end_line_q <= 5'h00;
         display_start_q <= `RST_ADDR;
         cursor_address_q <= `RST_ADDR;
      end else if (wr_acc && !bus_req.register_select) begin
         index_q <= bus_req.data[4:0];
      end else if (wr_acc) begin
         case (index_q)
            `IDX_HTOTAL: htotal_q <= bus_req.data;
            `IDX_HDISP: hdisp_q <= bus_req.data;
            `IDX_HSYNC_POS: hsync_position_q <= bus_req.data;
            `IDX_SYNC_WIDTHS: sync_widths_q <= bus_req.data;
            `IDX_VTOTAL: vertical_total_rows_q <= bus_req.data[6:0];
            `IDX_VADJUST: vertical_line_adjust_q <= bus_req.data[4:0];
            `IDX_VDISP: vertical_displayed_rows_q <= bus_req.data[6:0];
            `IDX_VSYNC_POS: vsync_row_position_q <= bus_req.data[6:0];
            `IDX_MODE: mode_control_q <= bus_req.data;
            `IDX_ROW_LINES: row_scan_lines_q <= bus_req.data[4:0];
            `IDX_CUR_START: cursor_start_line_q <= bus_req.data[6:0];
            `IDX_CUR_END: cursor_end_line_q <= bus_req.data[4:0];
            `IDX_START_HI: display_start_q[13:8] <= bus_req.data[5:0];
            `IDX_START_LO: display_start_q[7:0] <= bus_req.data;
            `IDX_CUR_HI: cursor_address_q[13:8] <= bus_req.data[5:0];
            `IDX_CUR_LO: cursor_address_q[7:0] <= bus_req.data;
            default: ; // pen pair and unused indices ignore writes
         endcase
      end
   end

   // read data, registered; only cursor and pen pairs return data
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata_q <= 8'h00;
         rdata_oe_q <= 1'b0;
      end else if (clk_en) begin
         rdata_oe_q <= rd_acc && bus_req.register_select;
         if (rd_acc && bus_req.register_select) begin
            rdata_q <= read_mux(index_q, cursor_address_q, pen_capture_q);
         end
      end
   end

   // frame structure decode
   assign line_end = (hcnt_q == htotal_q);
   assign row_end = line_end && (scan_q == row_scan_lines_q);
   always_comb begin
      frame_end = 1'b0;
      case (phase_q)
         PH_ROWS: frame_end = row_end && (row_q == vertical_total_rows_q)
                              && (vertical_line_adjust_q == 5'h00);
         PH_ADJUST: frame_end = line_end && (scan_q + 5'h01 == vertical_line_adjust_q);
         default: frame_end = 1'b1;
      endcase
   end

   // next position decode; syncs are set one edge ahead so that they line up
   // with the counters and leave the output stage in step with enable and address
   assign hnext = line_end ? 8'h00 : hcnt_q + 8'h01;
   // next edge opens scan line 0 of the sync row, by frame wrap or by row step
   assign vs_start = line_end && ((frame_end && vsync_row_position_q == 7'h00)
                     || (!frame_end && phase_q == PH_ROWS && row_end
                         && row_q != vertical_total_rows_q
                         && row_q + 7'h01 == vsync_row_position_q));

   // address: row base plus column; row/column keeps the row in the upper six bits
   always_comb begin
      if (rowcol) begin
         ma = {row_base_q[13:8], row_base_q[7:0] + hcnt_q};
      end else begin
         ma = row_base_q + {6'h00, hcnt_q};
      end
   end

   // horizontal counter, one step per character clock
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         hcnt_q <= 8'h00;
      end else if (clk_en) begin
         hcnt_q <= line_end ? 8'h00 : hcnt_q + 8'h01;
      end
   end

   // scan line, row counter, frame phase and field count
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         scan_q <= 5'h00;
         row_q <= 7'h00;
         phase_q <= PH_ROWS;
         field_q <= 5'h00;
      end else if (clk_en && frame_end) begin
         scan_q <= 5'h00;
         row_q <= 7'h00;
         phase_q <= PH_ROWS;
         field_q <= field_q + 5'h01;
      end else if (clk_en && line_end) begin
         case (phase_q)
            PH_ROWS: begin
               if (row_end && row_q == vertical_total_rows_q) begin
                  scan_q <= 5'h00;
                  phase_q <= PH_ADJUST;
               end else if (row_end) begin
                  scan_q <= 5'h00;
                  row_q <= row_q + 7'h01;
               end else begin
                  scan_q <= scan_q + 5'h01;
               end
            end
            PH_ADJUST: scan_q <= scan_q + 5'h01;
            default: phase_q <= PH_ROWS;
         endcase
      end
   end

   // in linear format the row base steps by a whole line, so non-displayed columns keep counting
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         row_base_q <= `RST_ADDR;
      end else if (clk_en && frame_end) begin
         row_base_q <= display_start_q;
      end else if (clk_en && row_end && phase_q == PH_ROWS) begin
         if (rowcol) begin
            row_base_q <= {row_base_q[13:8] + 6'h01, display_start_q[7:0]};
         end else begin
            row_base_q <= row_base_q + {6'h00, htotal_q} + 14'h0001;
         end
      end
   end

   // horizontal sync; width zero gives no pulse, a new start wins over an old end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         hsync_q <= 1'b0;
         hs_cnt_q <= 4'h0;
      end else if (clk_en) begin
         if (hnext == hsync_position_q && hs_width != 4'h0) begin
            hsync_q <= 1'b1;
            hs_cnt_q <= 4'h1;
         end else if (hsync_q && hs_cnt_q >= hs_width) begin
            hsync_q <= 1'b0;
         end else if (hsync_q) begin
            hs_cnt_q <= hs_cnt_q + 4'h1;
         end
      end
   end

   // vertical sync, counted in scan lines; width zero gives no pulse
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         vsync_q <= 1'b0;
         vs_cnt_q <= 4'h0;
      end else if (clk_en) begin
         if (vs_start && vs_width != 4'h0) begin
            vsync_q <= 1'b1;
            vs_cnt_q <= 4'h0;
         end else if (vsync_q && line_end && vs_cnt_q + 4'h1 >= vs_width) begin
            vsync_q <= 1'b0;
         end else if (vsync_q && line_end) begin
            vs_cnt_q <= vs_cnt_q + 4'h1;
         end
      end
   end

   // cursor match and blink
   always_comb begin
      case (blink_mode_t'(cursor_start_line_q[`BLINK_LSB +: 2]))
         BLINK_STEADY: blink_on = 1'b1;
         BLINK_OFF: blink_on = 1'b0;
         BLINK_FAST: blink_on = field_q[`BLINK_FAST_BIT];
         BLINK_SLOW: blink_on = field_q[`BLINK_SLOW_BIT];
         default: blink_on = 1'b0;
      endcase
   end
   assign cur_hit = (ma == cursor_address_q) && phase_q == PH_ROWS
                    && scan_q >= cursor_start_line_q[4:0]
                    && scan_q <= cursor_end_line_q && blink_on;

   // one extra stage for slow memories
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cur_now_q <= 1'b0;
      end else if (clk_en) begin
         cur_now_q <= cur_hit;
      end
   end

   // light pen: a rising edge latches the current address on this character clock
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pen_prev_q <= 1'b0;
         pen_capture_q <= `RST_ADDR;
      end else if (clk_en) begin
         pen_prev_q <= pen_strobe_input;
         if (pen_strobe_input && !pen_prev_q) begin
            pen_capture_q <= ma;
         end
      end
   end

   // registered video outputs; all lag the counters by one character clock, the delayed cursor by two
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         video_q <= '0;
      end else if (clk_en) begin
         video_q.hsync <= hsync_q;
         video_q.vsync <= vsync_q;
         video_q.display_enable <= phase_q == PH_ROWS && hcnt_q < hdisp_q
                                   && row_q < vertical_displayed_rows_q;
         video_q.cursor <= mode_control_q[`MODE_CUR_DELAY_BIT] ? cur_now_q : cur_hit;
         video_q.refresh_address_out <= ma;
         video_q.scan_row_address_out <= scan_q;
      end
   end

   assign video = video_q;
   assign bus_rdata = rdata_q;
   assign bus_rdata_oe = rdata_oe_q;

   // checks, sampled only on character clocks
   default clocking cc @(posedge ref_clk iff clk_en);
   endclocking
   default disable iff (srst);

   sequence s_last_row_end;
      phase_q == PH_ROWS && row_end && row_q == vertical_total_rows_q;
   endsequence

   // line length is total plus one
   a_hcount_wrap: assert property (line_end |=> hcnt_q == 8'h00)
      else $error("horizontal counter did not wrap");
   // enable follows the position one character later, like every output but the delayed cursor
   a_enable_region: assert property (##1 video_q.display_enable
      == ($past(hcnt_q) < $past(hdisp_q) && $past(row_q) < $past(vertical_displayed_rows_q)
      && $past(phase_q) == PH_ROWS))
      else $error("display enable outside region");
   // sync is already high on the character at the programmed position
   a_hsync_start: assert property (hcnt_q == hsync_position_q && hs_width != 4'h0
      && $stable(hsync_position_q) && $stable(sync_widths_q)
      |-> hsync_q ##1 video_q.hsync)
      else $error("hsync did not start");
   // narrowest pulse is a single character
   a_hsync_one: assert property ($rose(hsync_q) && hs_width == 4'h1
      && $stable(sync_widths_q) |=> !hsync_q)
      else $error("one character hsync too long");
   // scan count restarts on each new row
   a_scan_wrap: assert property (row_end && phase_q == PH_ROWS |=> scan_q == 5'h00)
      else $error("scan counter did not wrap");
   // a nonzero adjust always follows the last row
   a_adjust_entry: assert property (s_last_row_end ##0 vertical_line_adjust_q != 5'h00
      |=> phase_q == PH_ADJUST)
      else $error("adjust lines skipped");
   // each frame reloads the start address so scrolling takes effect
   a_frame_restart: assert property (frame_end
      |=> row_base_q == $past(display_start_q) && row_q == 7'h00)
      else $error("frame did not restart at start address");
   // suppressed mode must hide the cursor even with the delay stage on
   a_cursor_off: assert property (cursor_start_line_q[6:5] == 2'h1 [*3]
      |-> !video_q.cursor)
      else $error("suppressed cursor shown");
   // capture takes the address of the character that first sees the pen high
   a_pen_latch: assert property ($rose(pen_strobe_input)
      |=> pen_capture_q == $past(ma))
      else $error("pen address not captured");
   // a row step in row/column format bumps only the row field and restarts the column
   a_rowcol_row: assert property ((rowcol && row_end && phase_q == PH_ROWS
      && !frame_end) ##1 rowcol
      |-> ma[13:8] == $past(ma[13:8]) + 6'h01 && ma[7:0] == $past(display_start_q[7:0]))
      else $error("row field disturbed by column count");
   // vsync opens on scan line 0 of the programmed row, at its first character
   a_vsync_start: assert property (vs_start && vs_width != 4'h0
      |=> vsync_q && hcnt_q == 8'h00 && scan_q == 5'h00
      && row_q == $past(vsync_row_position_q))
      else $error("vsync not at start of sync row");
   // delayed cursor appears two characters after the match
   a_cursor_delay: assert property ((cur_hit && mode_control_q[`MODE_CUR_DELAY_BIT])
      ##1 mode_control_q[`MODE_CUR_DELAY_BIT] |=> video_q.cursor)
      else $error("delayed cursor missing");

endmodule // raster_video_timing_generator

`default_nettype wire

//--- tb/crt_host_model.sv
// host-side model: processor bus master and light pen for the timing generator
// assumes ref_clk is the character clock and clk_en is held high by the bench
// assumes the system multiplexes refresh RAM itself; no address line is driven here
`timescale 1ns/100ps
`default_nettype none
module crt_host_model
   import raster_timing_pkg::*;
(
   input wire logic ref_clk,
   output var bus_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   input wire logic bus_rdata_oe,
   input wire video_out_t video,
   output var logic pen_strobe_input
);
   localparam bus_req_t IDLE = '{cs_n: 1'b1, register_select: 1'b0, read_not_write: 1'b1,
                                 strobe: 1'b0, data: 8'h00};

   // bus idle and pen low from time zero
   initial begin
      bus_req = IDLE;
      pen_strobe_input = 1'b0;
   end

   // one strobed access, held through the taking edge, released right after it
   task automatic access(input logic rs, input logic rnw, input logic [7:0] wdata);
      @(posedge ref_clk);
      bus_req <= '{cs_n: 1'b0, register_select: rs, read_not_write: rnw, strobe: 1'b1,
                   data: wdata};
      @(posedge ref_clk);
      bus_req <= IDLE;
   endtask

   // index first, then the data access lands in the selected register
   task automatic wr(input logic [4:0] idx, input logic [7:0] wdata);
      access(1'b0, 1'b0, {3'h0, idx});
      access(1'b1, 1'b0, wdata);
   endtask

   // read data is taken in the cycle after the taking edge, when it is settled
   task automatic rd(input logic [4:0] idx, input logic rs, output logic [7:0] d,
                     output logic oe);
      access(1'b0, 1'b0, {3'h0, idx});
      access(rs, 1'b1, 8'h00);
      #1;
      d = bus_rdata;
      oe = bus_rdata_oe;
   endtask

   // pen rises; held a few cycles so a slow strobe cannot retrigger a capture
   task automatic pen_hit(output logic [13:0] seen);
      @(posedge ref_clk);
      pen_strobe_input <= 1'b1;
      @(posedge ref_clk);
      #1;
      seen = video.refresh_address_out;
      repeat (3) @(posedge ref_clk);
      pen_strobe_input <= 1'b0;
   endtask
endmodule // crt_host_model
`default_nettype wire

//--- tb/raster_video_timing_generator_tb_top.sv
// self-checking bench for the raster timing generator
// assumes the host model drives the bus and pen; clock enable held high
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module raster_video_timing_generator_tb_top
   import raster_timing_pkg::*;
;
   logic ref_clk, srst, bus_rdata_oe, pen_strobe_input;
   bus_req_t bus_req;
   logic [7:0] bus_rdata;
   video_out_t video;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   int per, n_de, n_cur, n_hs, n_vs;
   logic [13:0] cur_a;
   logic [4:0] cur_s;
   logic [7:0] r [16];

   raster_video_timing_generator raster_video_timing_generator_i (.ref_clk(ref_clk),
      .srst(srst), .clk_en(1'b1), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .bus_rdata_oe(bus_rdata_oe), .pen_strobe_input(pen_strobe_input), .video(video));
   crt_host_model crt_host_model_i (.ref_clk(ref_clk), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe), .video(video),
      .pen_strobe_input(pen_strobe_input));

   // 25 MHz character clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // hang guard, well above the few thousand cycles the run needs
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end

   task automatic results();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask

   function automatic logic sig(input int w);
      case (w)
         0: return video.hsync;
         1: return video.vsync;
         default: return video.display_enable;
      endcase
   endfunction

   // steps until the chosen output rises; k counts the steps taken
   task automatic wait_rise(input int w, output int k);
      logic was;
      k = 0;
      do begin
         was = sig(w);
         step();
         k++;
      end while (!(sig(w) === 1'b1 && was === 1'b0) && k < 300);
   endtask

   // one vsync period of statistics, cursor position of its last hit
   task automatic frame();
      logic was;
      wait_rise(1, per);
      {per, n_de, n_cur, n_hs, n_vs} = '0;
      do begin
         if (video.display_enable === 1'b1) n_de++;
         if (video.hsync === 1'b1) n_hs++;
         if (video.vsync === 1'b1) n_vs++;
         if (video.cursor === 1'b1) begin
            n_cur++;
            cur_a = video.refresh_address_out;
            cur_s = video.scan_row_address_out;
         end
         was = video.vsync;
         step();
         per++;
      end while (!(video.vsync === 1'b1 && was === 1'b0) && per < 300);
   endtask

   // first character of the frame: start address on scan line 0
   task automatic find_start();
      int k;
      k = 0;
      while (!(video.refresh_address_out === 14'h0100 &&
               video.scan_row_address_out === 5'h00) && k < 300) begin
         step();
         k++;
      end
   endtask

   // reset values, read-back, write-only, read-only and index-phase reads
   task automatic t_regs();
      logic [7:0] d;
      logic oe;
      crt_host_model_i.rd(5'h0E, 1'b1, d, oe);
      `CHK(d, 8'h00)
      `CHK(oe, 1'b1)
      crt_host_model_i.wr(5'h0E, 8'h2A);
      crt_host_model_i.wr(5'h0F, 8'hC3);
      crt_host_model_i.rd(5'h0E, 1'b1, d, oe);
      `CHK(d, 8'h2A)
      crt_host_model_i.rd(5'h0F, 1'b1, d, oe);
      `CHK(d, 8'hC3)
      crt_host_model_i.rd(5'h00, 1'b1, d, oe);
      `CHK(d, 8'h00)
      crt_host_model_i.rd(5'h0F, 1'b0, d, oe);
      `CHK(oe, 1'b0)
      crt_host_model_i.wr(5'h11, 8'h55);
      crt_host_model_i.rd(5'h11, 1'b1, d, oe);
      `CHK(d, 8'h00)
   endtask

   // whole-frame counts: 4-char lines, 2-line rows, 3 rows plus 1 adjust line
   task automatic t_frame();
      frame();
      `CHK(per, 28)
      `CHK(n_vs, 8)
      `CHK(n_hs, 7)
      `CHK(n_de, 8)
      `CHK(n_cur, 0)
   endtask

   // horizontal: displayed run, sync position from column 0, line period
   task automatic t_line();
      int k, d;
      wait_rise(2, k);
      d = 0;
      while (video.display_enable === 1'b1 && d < 10) begin
         step();
         d++;
      end
      `CHK(d, 2)
      wait_rise(0, k);
      `CHK(d + k, 3)
      wait_rise(0, k);
      `CHK(k, 4)
      find_start();
      wait_rise(1, k);
      `CHK(k, 8)
   endtask

   // address walk through blanked columns, row advance, then row/column format
   task automatic t_addr();
      find_start();
      for (int i = 0; i < 4; i++) begin
         `CHK(video.refresh_address_out, 14'h0100 + 14'(i))
         step();
      end
      `CHK(video.scan_row_address_out, 5'h01)
      `CHK(video.refresh_address_out, 14'h0100)
      repeat (4) step();
      `CHK(video.refresh_address_out, 14'h0104)
      crt_host_model_i.wr(5'h08, 8'h04);
      frame();
      find_start();
      repeat (8) step();
      `CHK(video.refresh_address_out, 14'h0200)
      crt_host_model_i.wr(5'h08, 8'h00);
   endtask

   // cursor match, line bounds, blank, delay and both blink rates
   task automatic t_cursor();
      int on, run, best;
      crt_host_model_i.wr(5'h0E, 8'h01);
      crt_host_model_i.wr(5'h0F, 8'h01);
      frame();
      frame();
      `CHK(n_cur, 1)
      `CHK(cur_a, 14'h0101)
      `CHK(cur_s, 5'h01)
      crt_host_model_i.wr(5'h0A, 8'h21);
      frame();
      frame();
      `CHK(n_cur, 0)
      crt_host_model_i.wr(5'h0A, 8'h01);
      crt_host_model_i.wr(5'h08, 8'h20);
      frame();
      frame();
      `CHK(cur_a, 14'h0102)
      crt_host_model_i.wr(5'h08, 8'h00);
      for (int c = 2; c < 4; c++) begin
         crt_host_model_i.wr(5'h0A, {1'b0, 2'(c), 5'h01});
         frame();
         {on, run, best} = '0;
         // each frame() call spends one field waiting, so every other field is seen
         repeat (64) begin
            frame();
            if (n_cur > 0) begin
               run++;
               on++;
            end
            else run = 0;
            if (run > best) best = run;
         end
         `CHK(on, 32)
         `CHK(best, (c == 2) ? 4 : 8)
      end
   endtask

   // pen capture equals the address shown after the edge that sees the rise
   task automatic t_pen();
      logic [13:0] a;
      logic [7:0] d;
      logic oe;
      crt_host_model_i.pen_hit(a);
      crt_host_model_i.rd(5'h10, 1'b1, d, oe);
      `CHK(d, {2'b00, a[13:8]})
      crt_host_model_i.rd(5'h11, 1'b1, d, oe);
      `CHK(d, a[7:0])
   endtask

   // main sequence; the timing table leaves the cursor off screen at first
   initial begin
      srst = 1'b1;
      r = '{8'h03, 8'h02, 8'h03, 8'h21, 8'h02, 8'h01, 8'h02, 8'h01,
            8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h3F, 8'hFF};
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      t_regs();
      for (int i = 0; i < 16; i++) crt_host_model_i.wr(5'(i), r[i]);
      frame();
      t_frame();
      t_line();
      t_addr();
      t_cursor();
      t_pen();
      results();
   end
endmodule // raster_video_timing_generator_tb_top
`default_nettype wire
